// *** src/fqc_pkg.sv ***
// Purpose: constants and types shared by the frame queue control block
// Assumes: 32-bit classic Wishbone register bus, byte addresses
// Notes: offsets are byte addresses of aligned words
`default_nettype none
package fqc_pkg;
    localparam logic [7:0] FQC_TX_CTL_OFS = 8'hC4;
    localparam logic [7:0] FQC_RX_END_OFS = 8'hC8;
    localparam logic [7:0] FQC_TX_END_OFS = 8'hCC;
    localparam logic [7:0] FQC_PAUSE_OFS = 8'hD0;
    localparam logic [7:0] FQC_RX_PATH_OFS = 8'hD4;
    localparam logic [7:0] FQC_TX_PATH_OFS = 8'hD8;
    localparam logic [7:0] FQC_RX_USED_OFS = 8'hC0;
    localparam int FQC_EN_BIT = 31;
    localparam int FQC_RST_BIT = 30;
    localparam int FQC_OFF_BIT = 20;
    localparam int FQC_OFF_LO = 8;
    localparam logic [6:0] FQC_RX_END_RST = 7'h17;
    localparam logic [5:0] FQC_TX_END_RST = 6'h17;
    localparam logic [6:0] FQC_THR_RST = 7'h00;
    localparam logic [6:0] FQC_END_LSB = 7'h7F;
    localparam int FQC_END_SHIFT = 7;
    localparam int FQC_UNIT_SHIFT = 9;
    localparam logic [15:0] FQC_MAX_BYTES = 16'h3000;
    typedef enum logic [1:0] {
        FQC_IDLE = 2'b00,
        FQC_SEND = 2'b01,
        FQC_DRAIN = 2'b11
    } fqc_tx_state_t;
endpackage : fqc_pkg
`default_nettype wire

// *** src/fqc_if.sv ***
// Purpose: byte accounting bundle between the top and the counter
// Assumes: one clock
// Notes: add and sub carry already rounded byte amounts
`default_nettype none
interface fqc_cnt_if;
    logic add;
    logic [15:0] add_bytes;
    logic sub;
    logic [15:0] sub_bytes;
    logic clear;
    logic [15:0] count;
    modport owner (input add, input add_bytes, input sub, input sub_bytes, input clear, output count);
    modport user (output add, output add_bytes, output sub, output sub_bytes, output clear, input count);
endinterface : fqc_cnt_if
`default_nettype wire

// *** src/fqc_used_counter.sv ***
// Purpose: byte occupancy counter for one frame queue
// Assumes: amounts already rounded to words
// Notes: saturates at zero and full scale to avoid wrap
`default_nettype none
module fqc_used_counter
    import fqc_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    fqc_cnt_if.owner cnt
);
    logic [15:0] used;
    wire [16:0] up = {1'b0, used} + (cnt.add ? {1'b0, cnt.add_bytes} : 17'h00000);
    wire [16:0] down = cnt.sub ? {1'b0, cnt.sub_bytes} : 17'h00000;
    wire [16:0] next_raw = (up < down) ? 17'h00000 : up - down;
    wire [15:0] next_used = next_raw[16] ? 16'hFFFF : next_raw[15:0];
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            used <= 16'h0000;
        end else if (cnt.clear) begin
            used <= 16'h0000;
        end else begin
            used <= next_used;
        end
    end
    assign cnt.count = used;
endmodule : fqc_used_counter
`default_nettype wire

// *** src/fqc_top.sv ***
// Purpose: frame queue control and status for the transmit and receive frame queues
// Assumes: classic Wishbone slave, 40 MHz clk, one-cycle frame events from queue logic
// Notes: frame byte amounts arrive unrounded; words, command words and checksums added here
`default_nettype none
module fqc_top
    import fqc_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic tx_wr_frame,
    input wire logic [15:0] tx_wr_len,
    input wire logic [15:0] tx_wr_extra,
    input wire logic tx_frame_pending,
    output logic tx_start,
    input wire logic tx_done,
    input wire logic tx_retry,
    input wire logic half_duplex,
    output logic tx_discard,
    output logic tx_queue_flush,
    output logic usb_ingress_flush,
    input wire logic rx_wr_frame,
    input wire logic [15:0] rx_wr_len,
    input wire logic [15:0] rx_wr_extra,
    input wire logic rx_rd_frame,
    input wire logic [15:0] rx_rd_len,
    input wire logic [15:0] rx_rd_extra,
    input wire logic tx_rd_frame,
    input wire logic [15:0] tx_rd_len,
    input wire logic [15:0] tx_rd_extra,
    input wire logic [15:0] usb_egress_bytes,
    input wire logic [15:0] usb_ingress_bytes,
    output logic pause_request,
    output logic [15:0] rx_queue_end_addr,
    output logic [15:0] tx_queue_end_addr
);
    ////////////////////////////////////////////////////////////////////////
    // register bus decode
    logic tx_queue_enable;
    logic tx_queue_off_flag;
    logic [6:0] rx_queue_end;
    logic [5:0] tx_queue_end;
    logic [6:0] pause_on_thr;
    logic [6:0] pause_off_thr;
    logic tx_rst_pulse;
    fqc_tx_state_t tx_state;
    fqc_tx_state_t next_tx_state;
    logic [15:0] rx_queue_bytes;
    logic [15:0] tx_queue_bytes;
    wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire bus_wr = bus_req & wb_we_i;
    wire hit_tx_ctl = wb_adr_i == FQC_TX_CTL_OFS;
    wire hit_rx_end = wb_adr_i == FQC_RX_END_OFS;
    wire hit_tx_end = wb_adr_i == FQC_TX_END_OFS;
    wire hit_pause = wb_adr_i == FQC_PAUSE_OFS;
    wire hit_rx_path = wb_adr_i == FQC_RX_PATH_OFS;
    wire hit_tx_path = wb_adr_i == FQC_TX_PATH_OFS;
    wire hit_rx_used = wb_adr_i == FQC_RX_USED_OFS;
    wire wr_tx_ctl_hi = bus_wr & hit_tx_ctl & wb_sel_i[3];
    wire wr_tx_ctl_b2 = bus_wr & hit_tx_ctl & wb_sel_i[2];
    wire wr_rx_end = bus_wr & hit_rx_end & wb_sel_i[0];
    wire wr_tx_end = bus_wr & hit_tx_end & wb_sel_i[0];
    wire wr_pause_lo = bus_wr & hit_pause & wb_sel_i[0];
    wire wr_pause_hi = bus_wr & hit_pause & wb_sel_i[1];
    wire [31:0] rd_tx_ctl = {tx_queue_enable, 1'b0, 9'h000, tx_queue_off_flag, 4'h0, tx_queue_bytes};
    wire [31:0] rd_rx_used = {16'h0000, rx_queue_bytes};
    wire [31:0] rd_pause = {17'h00000, pause_off_thr, 1'b0, pause_on_thr};
    wire [15:0] rx_path_total_bytes = rx_queue_bytes + usb_egress_bytes;
    wire [15:0] tx_path_total_bytes = tx_queue_bytes + usb_ingress_bytes;
    wire [31:0] rd_mux = hit_tx_ctl ? rd_tx_ctl :
                         hit_rx_used ? rd_rx_used :
                         hit_rx_end ? {25'h0000000, rx_queue_end} :
                         hit_tx_end ? {26'h0000000, tx_queue_end} :
                         hit_pause ? rd_pause :
                         hit_rx_path ? {rx_path_total_bytes, usb_egress_bytes} :
                         hit_tx_path ? {tx_path_total_bytes, usb_ingress_bytes} : 32'h00000000;

    // unmapped addresses ack with zero data so the master never hangs
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= bus_req;
            wb_dat_o <= (bus_req & ~wb_we_i) ? rd_mux : 32'h00000000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // configuration registers
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rx_queue_end <= FQC_RX_END_RST;
            tx_queue_end <= FQC_TX_END_RST;
            pause_on_thr <= FQC_THR_RST;
            pause_off_thr <= FQC_THR_RST;
        end else begin
            // no guard against resize in flight; software halts the path first
            if (wr_rx_end) begin
                rx_queue_end <= wb_dat_i[6:0];
            end
            if (wr_tx_end) begin
                tx_queue_end <= wb_dat_i[5:0];
            end
            if (wr_pause_lo) begin
                pause_on_thr <= wb_dat_i[6:0];
            end
            if (wr_pause_hi) begin
                pause_off_thr <= wb_dat_i[FQC_OFF_LO +: 7];
            end
        end
    end

    assign rx_queue_end_addr = {2'b00, rx_queue_end, FQC_END_LSB};
    assign tx_queue_end_addr = {3'b000, tx_queue_end, FQC_END_LSB};

    ////////////////////////////////////////////////////////////////////////
    // transmit enable, reset and disable sequence
    wire en_write = wr_tx_ctl_hi;
    wire next_enable = en_write ? wb_dat_i[FQC_EN_BIT] : tx_queue_enable;
    wire disable_edge = tx_queue_enable & ~next_enable;
    wire rst_write = wr_tx_ctl_hi & wb_dat_i[FQC_RST_BIT];
    wire clr_off = wr_tx_ctl_b2 & wb_dat_i[FQC_OFF_BIT];
    logic draining;
    wire drain_done = draining & (tx_state == FQC_IDLE);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            tx_queue_enable <= 1'b0;
            tx_rst_pulse <= 1'b0;
            draining <= 1'b0;
        end else begin
            tx_queue_enable <= next_enable;
            tx_rst_pulse <= rst_write;
            if (disable_edge) begin
                draining <= 1'b1;
            end else if (drain_done | tx_rst_pulse | next_enable) begin
                draining <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            tx_queue_off_flag <= 1'b0;
        end else if (drain_done) begin
            tx_queue_off_flag <= 1'b1;
        end else if (clr_off) begin
            tx_queue_off_flag <= 1'b0;
        end
    end

    assign tx_queue_flush = tx_rst_pulse;
    assign usb_ingress_flush = tx_rst_pulse;

    ////////////////////////////////////////////////////////////////////////
    // transmit frame sequencer
    // start only while enabled
    wire can_start = tx_queue_enable & tx_frame_pending;
    wire retry_dead = tx_retry & half_duplex & ~tx_queue_enable;

    always_comb begin
        next_tx_state = tx_state;
        unique case (tx_state)
            FQC_IDLE: begin
                if (can_start) begin
                    next_tx_state = FQC_SEND;
                end
            end
            FQC_SEND: begin
                if (tx_done | retry_dead) begin
                    next_tx_state = FQC_IDLE;
                end else if (~tx_queue_enable) begin
                    next_tx_state = FQC_DRAIN;
                end
            end
            FQC_DRAIN: begin
                if (tx_done | retry_dead) begin
                    next_tx_state = FQC_IDLE;
                end
            end
            default: begin
                next_tx_state = FQC_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            tx_state <= FQC_IDLE;
        end else if (tx_rst_pulse) begin
            tx_state <= FQC_IDLE;
        end else begin
            tx_state <= next_tx_state;
        end
    end

    assign tx_start = (tx_state == FQC_IDLE) & can_start & ~tx_rst_pulse;
    assign tx_discard = retry_dead & (tx_state != FQC_IDLE);

    ////////////////////////////////////////////////////////////////////////
    // byte accounting
    // round to word, add extras
    function automatic logic [15:0] fqc_round(input logic [15:0] len, input logic [15:0] extra);
        logic [15:0] words;
        words = (len + 16'h0003) & 16'hFFFC;
        return words + extra;
    endfunction : fqc_round

    fqc_cnt_if tx_cnt ();
    fqc_cnt_if rx_cnt ();

    assign tx_cnt.add = tx_wr_frame;
    assign tx_cnt.add_bytes = fqc_round(tx_wr_len, tx_wr_extra);
    assign tx_cnt.sub = tx_rd_frame | (tx_discard & tx_rd_frame);
    assign tx_cnt.sub_bytes = fqc_round(tx_rd_len, tx_rd_extra);
    assign tx_cnt.clear = tx_rst_pulse;
    assign tx_queue_bytes = tx_cnt.count;

    assign rx_cnt.add = rx_wr_frame;
    assign rx_cnt.add_bytes = fqc_round(rx_wr_len, rx_wr_extra);
    assign rx_cnt.sub = rx_rd_frame;
    assign rx_cnt.sub_bytes = fqc_round(rx_rd_len, rx_rd_extra);
    assign rx_cnt.clear = 1'b0;
    assign rx_queue_bytes = rx_cnt.count;

    fqc_used_counter u_tx_used (
        .clk(clk),
        .sys_rst(sys_rst),
        .cnt(tx_cnt.owner)
    );
    fqc_used_counter u_rx_used (
        .clk(clk),
        .sys_rst(sys_rst),
        .cnt(rx_cnt.owner)
    );

    ////////////////////////////////////////////////////////////////////////
    // pause watermarks, hysteresis between on and off thresholds
    // 512-byte units
    wire [6:0] rx_units = rx_queue_bytes[FQC_UNIT_SHIFT +: 7];
    wire pause_on_hit = rx_units >= pause_on_thr;
    wire pause_off_hit = rx_units <= pause_off_thr;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pause_request <= 1'b0;
        end else if (pause_on_hit) begin
            pause_request <= 1'b1;
        end else if (pause_off_hit) begin
            pause_request <= 1'b0;
        end
    end
endmodule : fqc_top
`default_nettype wire

// *** tb/fqc_top_asserts.sv ***
// Purpose: port checks of the frame queue control block
// Assumes: bound to fqc_top, one clock
// Notes: byte counts are judged by the bench, not here
`default_nettype none
module fqc_top_asserts
    import fqc_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic tx_frame_pending,
    input wire logic tx_start,
    input wire logic tx_retry,
    input wire logic half_duplex,
    input wire logic tx_discard,
    input wire logic tx_queue_flush,
    input wire logic usb_ingress_flush,
    input wire logic [15:0] rx_queue_end_addr,
    input wire logic [15:0] tx_queue_end_addr
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    wire logic req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire logic rst_wr = wb_ack_o && wb_we_i && wb_adr_i == FQC_TX_CTL_OFS && wb_sel_i[3] && wb_dat_i[FQC_RST_BIT];
    ////////////////////////////////////////
    a_ack_next: assert property (req |=> wb_ack_o) else $error("ack late");
    a_ack_drop: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
    a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data without ack");
    a_start_pend: assert property (tx_start |-> tx_frame_pending) else $error("start with nothing queued");
    a_start_once: assert property (tx_start |=> !tx_start) else $error("double start");
    a_discard_retry: assert property (tx_discard |-> tx_retry && half_duplex) else $error("bad discard");
    a_flush_pair: assert property (tx_queue_flush == usb_ingress_flush) else $error("flush split");
    a_flush_cause: assert property (rst_wr |-> tx_queue_flush) else $error("no flush");
    a_rx_end_form: assert property (rx_queue_end_addr[6:0] == FQC_END_LSB && rx_queue_end_addr[15:14] == 2'h0)
        else $error("rx end form");
    a_tx_end_form: assert property (tx_queue_end_addr[6:0] == FQC_END_LSB && tx_queue_end_addr[15:13] == 3'h0)
        else $error("tx end form");
    a_end_reset: assert property ($fell(sys_rst) |-> rx_queue_end_addr == 16'h0BFF && tx_queue_end_addr == 16'h0BFF)
        else $error("end reset");
    c_start: cover property (tx_start);
    c_discard: cover property (tx_discard);
    c_flush: cover property (tx_queue_flush);
endmodule : fqc_top_asserts
bind fqc_top fqc_top_asserts u_chk (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .tx_frame_pending(tx_frame_pending), .tx_start(tx_start), .tx_retry(tx_retry),
    .half_duplex(half_duplex), .tx_discard(tx_discard), .tx_queue_flush(tx_queue_flush),
    .usb_ingress_flush(usb_ingress_flush), .rx_queue_end_addr(rx_queue_end_addr),
    .tx_queue_end_addr(tx_queue_end_addr));
`default_nettype wire

// *** tb/fqc_mac_model.sv ***
// Purpose: mac transmit side, answers starts with done
// Assumes: one start pulse per frame
// Notes: lat is cycles from start to done; retry only when asked
`default_nettype none
module fqc_mac_model #(
    parameter int LAT = 20
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic tx_start,
    input wire logic tx_discard,
    input wire logic retry_cmd,
    output logic tx_done,
    output logic tx_retry
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt <= 0;
            tx_done <= 1'b0;
            tx_retry <= 1'b0;
        end else begin
            tx_done <= 1'b0;
            tx_retry <= 1'b0;
            if (tx_start) cnt <= LAT;
            // frame dropped, so no done follows
            else if (tx_discard) cnt <= 0;
            else if (cnt > 0 && retry_cmd && !tx_retry) tx_retry <= 1'b1;
            else if (cnt == 1) begin
                tx_done <= 1'b1;
                cnt <= 0;
            end else if (cnt > 1) cnt <= cnt - 1;
        end
    end
endmodule : fqc_mac_model
`default_nettype wire

// *** tb/tb_fqc_top.sv ***
// Purpose: self checking bench for fqc_top
// Assumes: 40 MHz clock, mac model on the transmit side
// Notes: frame events share one length and extra bus
`default_nettype none
module tb_fqc_top;
    import fqc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, sys_rst = 1, cyc = 0, we = 0, pend = 0, hd = 0, rcmd = 0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0, fev = 4'h0;
    logic [31:0] dat = 32'h0, rdat, wb_dat_o;
    logic [15:0] flen = 16'h0, fext = 16'h0, rx_end, tx_end;
    logic wb_ack_o, tx_start, tx_done, tx_retry, tx_discard, fl_a, fl_b, pause;
    int num_errors = 0, cmp_count = 0, n_start = 0, n_done = 0, n_disc = 0, n_flush = 0;
    fqc_top u_dut (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .tx_wr_frame(fev[0]),
        .tx_wr_len(flen), .tx_wr_extra(fext), .tx_frame_pending(pend), .tx_start(tx_start), .tx_done(tx_done),
        .tx_retry(tx_retry), .half_duplex(hd), .tx_discard(tx_discard), .tx_queue_flush(fl_a),
        .usb_ingress_flush(fl_b), .rx_wr_frame(fev[2]), .rx_wr_len(flen), .rx_wr_extra(fext), .rx_rd_frame(fev[3]),
        .rx_rd_len(flen), .rx_rd_extra(fext), .tx_rd_frame(fev[1]), .tx_rd_len(flen), .tx_rd_extra(fext),
        .usb_egress_bytes(16'h0010), .usb_ingress_bytes(16'h0020), .pause_request(pause),
        .rx_queue_end_addr(rx_end), .tx_queue_end_addr(tx_end));
    fqc_mac_model #(.LAT(20)) u_mac (.clk(clk), .sys_rst(sys_rst), .tx_start(tx_start), .tx_discard(tx_discard),
        .retry_cmd(rcmd), .tx_done(tx_done), .tx_retry(tx_retry));
    initial forever #12.5 clk = ~clk;
    always @(negedge clk) begin
        n_start += (tx_start === 1'b1);
        n_done += (tx_done === 1'b1);
        n_disc += (tx_discard === 1'b1);
        n_flush += (fl_a === 1'b1 && fl_b === 1'b1);
    end
    ////////////////////////////////////////
    task chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task acc(input logic [7:0] a, input logic w, input logic [31:0] d, input logic [3:0] s);
        @(posedge clk);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= s;
        // ack judged at the rising edge; data taken and request dropped at that same edge
        do begin
            @(posedge clk);
        end while (wb_ack_o !== 1'b1);
        rdat = wb_dat_o;
        cyc <= 1'b0;
    endtask : acc
    task wr(input logic [7:0] a, input logic [31:0] d);
        acc(a, 1'b1, d, 4'hF);
    endtask : wr
    task rdc(input logic [7:0] a, input logic [31:0] e);
        acc(a, 1'b0, 32'h0, 4'hF);
        chk(rdat, e);
    endtask : rdc
    task frm(input int k, input logic [15:0] l, input logic [15:0] e);
        @(posedge clk);
        fev[k] <= 1'b1;
        flen <= l;
        fext <= e;
        @(posedge clk);
        fev <= 4'h0;
        repeat (3) @(negedge clk);
    endtask : frm
    task automatic wt(ref int c, input int v);
        for (int i = 0; i < 200 && c < v; i++) @(negedge clk);
        chk(c, v);
    endtask : wt
    ////////////////////////////////////////
    task t_regs;
        rdc(FQC_RX_END_OFS, 32'h00000017);
        rdc(FQC_TX_END_OFS, 32'h00000017);
        chk({rx_end, tx_end}, 32'h0BFF0BFF);
        rdc(8'hE0, 32'h0);
        acc(FQC_RX_END_OFS, 1'b1, 32'h0000007F, 4'hE);
        rdc(FQC_RX_END_OFS, 32'h00000017);
        wr(FQC_RX_END_OFS, 32'hFFFFFFFF);
        wr(FQC_TX_END_OFS, 32'hFFFFFFFF);
        rdc(FQC_RX_END_OFS, 32'h0000007F);
        rdc(FQC_TX_END_OFS, 32'h0000003F);
        chk({rx_end, tx_end}, 32'h3FFF1FFF);
        // resize only while both paths are idle
        wr(FQC_RX_END_OFS, 32'h17);
        wr(FQC_TX_END_OFS, 32'h17);
        $display("test regs done");
    endtask : t_regs
    task t_used;
        frm(0, 16'd5, 16'd8);
        frm(0, 16'd64, 16'd0);
        rdc(FQC_TX_CTL_OFS, 32'h00000050);
        rdc(FQC_TX_PATH_OFS, 32'h00700020);
        frm(1, 16'd5, 16'd8);
        rdc(FQC_TX_CTL_OFS, 32'h00000040);
        $display("test used done");
    endtask : t_used
    task t_pause;
        // thresholds set before any receive frame is queued
        wr(FQC_PAUSE_OFS, 32'h00000102);
        rdc(FQC_PAUSE_OFS, 32'h00000102);
        frm(2, 16'd1020, 16'd0);
        chk(pause, 1'b0);
        frm(2, 16'd4, 16'd0);
        chk(pause, 1'b1);
        rdc(FQC_RX_USED_OFS, 32'h00000400);
        rdc(FQC_RX_PATH_OFS, 32'h04100010);
        frm(3, 16'd600, 16'd0);
        chk(pause, 1'b0);
        rdc(FQC_RX_USED_OFS, 32'h000001A8);
        $display("test pause done");
    endtask : t_pause
    task t_disable;
        wr(FQC_TX_CTL_OFS, 32'h80000000);
        pend <= 1'b1;
        wt(n_start, 1);
        wr(FQC_TX_CTL_OFS, 32'h0);
        rdc(FQC_TX_CTL_OFS, 32'h00000040);
        wt(n_done, 1);
        repeat (3) @(negedge clk);
        rdc(FQC_TX_CTL_OFS, 32'h00100040);
        chk(n_start, 1);
        wr(FQC_TX_CTL_OFS, 32'h00100000);
        rdc(FQC_TX_CTL_OFS, 32'h00000040);
        $display("test disable done");
    endtask : t_disable
    task t_discard;
        wr(FQC_TX_CTL_OFS, 32'h80000000);
        wt(n_start, 2);
        wr(FQC_TX_CTL_OFS, 32'h0);
        hd <= 1'b1;
        @(posedge clk);
        rcmd <= 1'b1;
        @(posedge clk);
        rcmd <= 1'b0;
        wt(n_disc, 1);
        repeat (4) @(negedge clk);
        chk(n_start, 2);
        rdc(FQC_TX_CTL_OFS, 32'h00100040);
        hd <= 1'b0;
        pend <= 1'b0;
        wr(FQC_TX_CTL_OFS, 32'h00100000);
        $display("test discard done");
    endtask : t_discard
    task t_reset;
        // queue already disabled before its reset
        wr(FQC_TX_CTL_OFS, 32'h40000000);
        wt(n_flush, 1);
        rdc(FQC_TX_CTL_OFS, 32'h0);
        $display("test reset done");
    endtask : t_reset
    task final_report;
        $display("checks %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : final_report
    initial begin
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        t_regs;
        t_used;
        t_pause;
        t_disable;
        t_discard;
        t_reset;
        final_report;
    end
    // about 180 cycles needed; generous margin
    initial begin
        repeat (5000) @(posedge clk);
        num_errors++;
        final_report;
    end
endmodule : tb_fqc_top
`default_nettype wire
